// ==== flow_ctl_defs.vh ====
/*
 Constants of the conversion flow control block: register offsets, bit positions,
 access selections and timing counts.
 Assumes a 50 MHz bus clock and an AXI4-Lite slave with 32-bit data.
*/
// Summary of operation
// - With the converter enabled, flow bit changes take effect after three bus clocks.
// - All flow bits clear while the converter is disabled or soft-reset.
// - Flow bits set only while enabled; writing zero leaves a bit unchanged.
// - Restart mode: sampling starts two bus plus two conversion clocks after start.
// - Back-to-back restart mode: next sample five bus plus two conversion clocks later.
// - Trigger mode: restart also raises start; both bits clear together.
// - Trigger mode: sampling starts five bus clocks after the start bit drops.
// - Abort bit 7 aborts the sequence and list at the next conversion boundary.
// - Abort bit clears only once the sequence is aborted and converter idle.
// - Bus write of one to a set abort bit keeps it and flags overrun.
// - Internal abort line sets abort when selected; repeat while set is overrun.
// - Restart arriving early, without abort or end of list, sets abort automatically.
// - Automatic abort also sets the unexpected restart error flag.
// - Start bit 6 begins a sequence when nothing is converting.
// - Restart mode: start bit clears when the first conversion of the sequence begins sampling.
// - Bus write of one to a set start bit keeps it and sets start overrun error.
// - Internal start request while start bit set sets start overrun error.
// - Restart bit 5 loads top-of-list command when idle; clears once loaded.
`ifndef FLOW_CTL_DEFS_VH
`define FLOW_CTL_DEFS_VH
`define FLOW_REG_INDEX     3'h5
`define FLOW_REG_ADDR      {`FLOW_REG_INDEX, 2'h0}
`define STATUS_REG_ADDR    5'h08
`define CONTROL_REG_ADDR   5'h0c
`define BIT_ABORT          7
`define BIT_START          6
`define BIT_RESTART        5
`define BIT_SWAP           4
`define BIT_ERR_RESTART    0
`define BIT_ERR_START      1
`define BIT_ERR_OVERRUN    2
`define BIT_BUSY           3
`define BIT_ENABLE         0
`define BIT_SOFT_RESET     1
`define BIT_SEQUENCE_START_FLAG_MODE      2
`define BIT_SEL_LO         4
`define ACC_NONE           2'h0
`define ACC_BUS            2'h1
`define ACC_INTERNAL       2'h2
`define LATENCY_CYCLES     2'h3
`define RESTART_BUS_CYC    3'h2
`define B2B_BUS_CYC        3'h5
`define SEQUENCE_START_FLAG_BUS_CYC       3'h5
`define CONV_PUMP_CYC      3'h2
`define CONV_PERIOD_CYC    4'ha
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// ==== flow_ctl.v ====
/*
 Conversion flow control of an on-chip converter: abort, start, restart and
 list swap ready bits with overrun and error flagging, reached over AXI4-Lite.
 Assumes synchronous inputs, one 50 MHz clock and an internal request source
 that pulses its request lines for one cycle.
*/
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "flow_ctl_defs.vh"
module flow_ctl (
   input  wire        clock,
   input  wire        rst_n,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        abort_request,
   input  wire        start_request,
   input  wire        restart_request,
   input  wire        swap_request,
   input  wire        end_of_list,
   output reg         sample_start,
   output reg         conversion_busy
);
   ////////////////////////////////////////////////////////////////////////////
   // Registers and working state
   reg  [7:0] conversion_flow_control;
   reg  [2:0] error_flags;
   reg  [7:0] control;
   reg  [4:0] aw_addr;
   reg [31:0] w_data;
   reg  [3:0] w_strb;
   reg        aw_held;
   reg        w_held;
   reg  [1:0] latency;
   reg  [3:0] pend_set;
   reg  [3:0] pend_twice;
   reg  [2:0] bus_cnt;
   reg  [2:0] conv_cnt;
   reg  [3:0] period_cnt;
   reg        first_conv;
   reg  [7:0] next_flow;
   reg  [2:0] next_err;

   // Sequencer states, one-hot
   localparam ST_IDLE   = 4'b0001;
   localparam ST_LOAD   = 4'b0010;
   localparam ST_WAIT   = 4'b0100;
   localparam ST_CONV   = 4'b1000;
   reg  [3:0] state;

   // Decoded control fields and the committed write
   wire enabled    = control[`BIT_ENABLE] & ~control[`BIT_SOFT_RESET];
   wire sequence_start_flag_mode  = control[`BIT_SEQUENCE_START_FLAG_MODE];
   wire [1:0] source = control[`BIT_SEL_LO+1:`BIT_SEL_LO];
   wire bus_owns   = (source == `ACC_BUS);
   wire int_owns   = (source == `ACC_INTERNAL);
   wire do_write   = aw_held & w_held & ~s_axi_bvalid;
   wire flow_write = do_write & (aw_addr == `FLOW_REG_ADDR) & w_strb[0];

   // Register word of an address, zero for unmapped ones
   function [31:0] read_word;
      input [4:0] addr;
      begin
         case (addr)
            `FLOW_REG_ADDR:    read_word = {24'h000000, conversion_flow_control};
            `STATUS_REG_ADDR:  read_word = {28'h0000000, conversion_busy, error_flags};
            `CONTROL_REG_ADDR: read_word = {24'h000000, control};
            default:           read_word = 32'h00000000;
         endcase
      end
   endfunction

   // Decode of a mapped register address
   function mapped;
      input [4:0] addr;
      begin
         mapped = (addr == `FLOW_REG_ADDR) | (addr == `STATUS_REG_ADDR) |
                  (addr == `CONTROL_REG_ADDR);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 5'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         control       <= 8'h00;
      end else begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         // Address and data may come in either order; the response waits for both
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_addr == `CONTROL_REG_ADDR && w_strb[0])
               control <= w_data[7:0];
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Soft reset lasts one cycle, then clears itself
         if (control[`BIT_SOFT_RESET])
            control[`BIT_SOFT_RESET] <= 1'b0;
         // Read data follows one cycle after the address is taken
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_word(s_axi_araddr);
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Set requests from the selected source, held through the latency window
   // Swap ready is honoured only together with restart
   wire [3:0] req_bus = flow_write & bus_owns ? {w_data[`BIT_ABORT], w_data[`BIT_START],
                        w_data[`BIT_RESTART], w_data[`BIT_SWAP] & w_data[`BIT_RESTART]}
                        : 4'h0;
   wire [3:0] req_int = int_owns ? {abort_request, start_request, restart_request,
                        swap_request & restart_request} : 4'h0;
   wire [3:0] req_all = req_bus | req_int;

   ////////////////////////////////////////////////////////////////////////////
   // Flow bits and error flags
   always @* begin
      next_flow = conversion_flow_control;
      next_err  = error_flags;
      if (latency == `LATENCY_CYCLES) begin
         // Repeated abort, start or restart requests on a set bit only raise flags
         if (pend_twice[3])
            next_err[`BIT_ERR_OVERRUN] = 1'b1;
         if (pend_twice[1])
            next_err[`BIT_ERR_OVERRUN] = 1'b1;
         if (pend_twice[2])
            next_err[`BIT_ERR_START] = 1'b1;
         // A restart while a sequence runs and end of list is low forces an abort
         if (pend_set[1] & ~next_flow[`BIT_ABORT] & ~end_of_list &
             (state != ST_IDLE)) begin
            next_flow[`BIT_ABORT] = 1'b1;
            next_err[`BIT_ERR_RESTART] = 1'b1;
         end
         if (pend_set[1] & sequence_start_flag_mode)
            next_flow[`BIT_START] = 1'b1;
         next_flow[`BIT_ABORT]   = next_flow[`BIT_ABORT] | pend_set[3];
         next_flow[`BIT_START]   = next_flow[`BIT_START] | pend_set[2];
         next_flow[`BIT_RESTART] = next_flow[`BIT_RESTART] | pend_set[1];
         next_flow[`BIT_SWAP]    = next_flow[`BIT_SWAP] | pend_set[0];
      end

      // Clears driven by the sequencer
      if (state == ST_IDLE && conversion_flow_control[`BIT_ABORT])
         next_flow[`BIT_ABORT] = 1'b0;
      if (state == ST_LOAD) begin
         next_flow[`BIT_RESTART] = 1'b0;
         next_flow[`BIT_SWAP]    = 1'b0;
         if (sequence_start_flag_mode)
            next_flow[`BIT_START] = 1'b0;
      end
      if (state == ST_WAIT && !sequence_start_flag_mode && bus_cnt == 3'h0 && conv_cnt == 3'h0 &&
          first_conv)
         next_flow[`BIT_START] = 1'b0;

      // Disable or soft reset overrides every set and clear
      if (!enabled) begin
         next_flow = 8'h00;
         next_err  = 3'h0;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conversion_flow_control <= 8'h00;
         error_flags             <= 3'h0;
         latency                 <= 2'h0;
         pend_set                <= 4'h0;
         pend_twice              <= 4'h0;
      end else begin
         conversion_flow_control <= next_flow;
         error_flags             <= next_err;
         if (!enabled) begin
            latency    <= 2'h0;
            pend_set   <= 4'h0;
            pend_twice <= 4'h0;
         // Requests inside the latency window are not taken
         end else if (latency == 2'h0 || latency == `LATENCY_CYCLES) begin
            if (req_all != 4'h0) begin
               latency    <= 2'h1;
               pend_set   <= req_all & ~{conversion_flow_control[7:4]};
               pend_twice <= req_all & conversion_flow_control[7:4];
            end else begin
               latency    <= 2'h0;
               pend_set   <= 4'h0;
               pend_twice <= 4'h0;
            end
         end else begin
            latency <= latency + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: list load, pump delay, conversion period
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state           <= ST_IDLE;
         bus_cnt         <= 3'h0;
         conv_cnt        <= 3'h0;
         period_cnt      <= 4'h0;
         first_conv      <= 1'b0;
         sample_start    <= 1'b0;
         conversion_busy <= 1'b0;
      end else begin
         sample_start    <= 1'b0;
         conversion_busy <= (state != ST_IDLE);
         case (state)
            ST_IDLE: begin
               if (conversion_flow_control[`BIT_RESTART] & ~conversion_flow_control[`BIT_ABORT])
                  state <= ST_LOAD;
               else if (conversion_flow_control[`BIT_START] & enabled) begin
                  state      <= ST_WAIT;
                  bus_cnt    <= `RESTART_BUS_CYC - 3'h1;
                  conv_cnt   <= `CONV_PUMP_CYC;
                  first_conv <= 1'b1;
               end
            end
            // Restart mode returns to idle after the load and waits for start
            ST_LOAD: begin
               state <= sequence_start_flag_mode ? ST_WAIT : ST_IDLE;
               bus_cnt    <= `SEQUENCE_START_FLAG_BUS_CYC - 3'h1;
               conv_cnt   <= 3'h0;
               first_conv <= 1'b1;
            end
            ST_WAIT: begin
               if (!enabled || conversion_flow_control[`BIT_ABORT])
                  state <= ST_IDLE;
               else if (bus_cnt != 3'h0)
                  bus_cnt <= bus_cnt - 3'h1;
               else if (conv_cnt != 3'h0)
                  conv_cnt <= conv_cnt - 3'h1;
               else begin
                  state        <= ST_CONV;
                  sample_start <= 1'b1;
                  period_cnt   <= `CONV_PERIOD_CYC;
                  first_conv   <= 1'b0;
               end
            end
            // Disable stops at once; abort and list end wait for the boundary
            ST_CONV: begin
               if (!enabled)
                  state <= ST_IDLE;
               else if (period_cnt != 4'h0)
                  period_cnt <= period_cnt - 4'h1;
               else if (conversion_flow_control[`BIT_ABORT] || end_of_list)
                  state <= ST_IDLE;
               else begin
                  state    <= ST_WAIT;
                  bus_cnt  <= `B2B_BUS_CYC - 3'h1;
                  conv_cnt <= `CONV_PUMP_CYC;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // flow_ctl

// ==== flow_ctl_props.sv ====
/* Port assertions for flow_ctl.
   Assumes it is bound to flow_ctl and a master offering aw and w together. */
`timescale 1ns/1ps
`include "flow_ctl_defs.vh"
module flow_ctl_props (
   input wire        clock,
   input wire        rst_n,
   input wire [4:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0]  s_axi_wstrb,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        sample_start,
   input wire        conversion_busy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
   wire ctl_off = wr_go && s_axi_awaddr == `CONTROL_REG_ADDR && !s_axi_wdata[`BIT_ENABLE];
   wire go_start = wr_go && s_axi_awaddr == `FLOW_REG_ADDR && s_axi_wdata[`BIT_START];
   ////////////////////////////////////////////////////////////////////////////////
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   r_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp != `RESP_OKAY
      |-> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad error read");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
   b_after_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing");
   sample_gap_a: assert property (sample_start |=> !sample_start [*8])
      else $error("samples too close");
   sample_busy_a: assert property (sample_start |-> conversion_busy)
      else $error("sample while idle");
   start_late_a: assert property (go_start && !conversion_busy |=> !sample_start [*4])
      else $error("start took effect too soon");
   off_idle_a: assert property (ctl_off |-> ##[1:8] !conversion_busy)
      else $error("busy after disable");
   rst_quiet_a: assert property ($rose(rst_n) |-> !sample_start && !conversion_busy)
      else $error("activity at reset release");
   cover property (sample_start);
   cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
   cover property ($fell(conversion_busy));
endmodule // flow_ctl_props
bind flow_ctl flow_ctl_props props (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .sample_start(sample_start), .conversion_busy(conversion_busy));

// ==== flow_req_model.sv ====
/* Internal request source: turns a bench command into one-cycle request pulses.
   Assumes the bench drives fire for one cycle; bits are abort, start, restart, swap. */
`timescale 1ns/1ps
module flow_req_model (
   input  wire       clock,
   input  wire       rst_n,
   input  wire [3:0] fire,
   output reg  [3:0] req
);
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         req <= 4'h0;
      else
         req <= fire;
   end
endmodule // flow_req_model

// ==== test_flow_ctl.sv ====
/* Self-checking bench for flow_ctl over AXI4-Lite and the internal request lines.
   Assumes flow_ctl_defs.vh, flow_req_model and the bound checker. */
`timescale 1ns/1ps
`include "flow_ctl_defs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_flow_ctl;
   reg         clock = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   reg  [4:0]  awaddr = 0, araddr = 0;
   reg  [3:0]  wstrb = 0, fire = 0;
   reg  [31:0] wdata = 0, rd;
   reg  [1:0]  rs;
   reg         seen;
   reg         eol = 0;
   wire        awready, wready, bvalid, arready, rvalid, sample_start, conversion_busy;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [3:0]  req;
   int         fails = 0, checks_done = 0, cyc = 0;
   flow_ctl dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .abort_request(req[0]), .start_request(req[1]), .restart_request(req[2]),
      .swap_request(req[3]), .end_of_list(eol), .sample_start(sample_start),
      .conversion_busy(conversion_busy));
   flow_req_model partner (.clock(clock), .rst_n(rst_n), .fire(fire), .req(req));
   initial forever #10 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input [4:0] a, input [31:0] d);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rdr(input [4:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic chk_rd(input string n, input [4:0] a, input [31:0] m, input [31:0] e);
      rdr(a);
      `CHK(n, e, rd & m)
   endtask
   task automatic pulse(input [3:0] f);
      @(posedge clock);
      fire <= f;
      @(posedge clock);
      fire <= 4'h0;
   endtask
   task automatic pulse2(input [3:0] f);
      pulse(f);
      repeat (2) @(posedge clock);
      pulse(f);
   endtask
   // Bounded wait for a sample pulse or for the sequencer to go idle
   task automatic wait_on(input bit idle, input string n);
      seen = 0;
      for (int i = 0; i < 300 && !seen; i++) begin
         @(posedge clock);
         seen = idle ? !conversion_busy : sample_start;
      end
      `CHK(n, 1'b1, seen)
   endtask
   task results;
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      chk_rd("flow after reset", `FLOW_REG_ADDR, 32'hff, 32'h0);
      chk_rd("status after reset", `STATUS_REG_ADDR, 32'hf, 32'h0);
      rdr(5'h00);
      `CHK("unmapped resp", `RESP_SLVERR, rs)
      wr(`FLOW_REG_ADDR, 32'hf0);
      chk_rd("flow set while off", `FLOW_REG_ADDR, 32'hff, 32'h0);
      wr(`CONTROL_REG_ADDR, 32'h11);
      wr(`FLOW_REG_ADDR, 32'h10);
      chk_rd("swap alone", `FLOW_REG_ADDR, 32'hff, 32'h0);
      wr(`FLOW_REG_ADDR, 32'h30);
      chk_rd("restart and swap", `FLOW_REG_ADDR, 32'h30, 32'h30);
      chk_rd("restart loaded", `FLOW_REG_ADDR, 32'hff, 32'h0);
      wr(`FLOW_REG_ADDR, 32'h40);
      wr(`FLOW_REG_ADDR, 32'h40);
      wait_on(0, "bus start sample");
      chk_rd("start cleared", `FLOW_REG_ADDR, 32'h40, 32'h0);
      chk_rd("busy", `STATUS_REG_ADDR, 32'h8, 32'h8);
      wr(`FLOW_REG_ADDR, 32'h80);
      wr(`FLOW_REG_ADDR, 32'h80);
      wait_on(1, "bus abort idle");
      chk_rd("abort cleared", `FLOW_REG_ADDR, 32'h80, 32'h0);
      chk_rd("bus overruns", `STATUS_REG_ADDR, 32'h7, 32'h6);
      wr(`CONTROL_REG_ADDR, 32'h23);
      chk_rd("soft reset clears", `STATUS_REG_ADDR, 32'h7, 32'h0);
      wr(`FLOW_REG_ADDR, 32'h40);
      repeat (10) @(posedge clock);
      chk_rd("bus write ignored", `FLOW_REG_ADDR, 32'hff, 32'h0);
      pulse2(4'h2);
      wait_on(0, "internal start sample");
      pulse2(4'h1);
      wait_on(1, "internal abort idle");
      pulse(4'h2);
      wait_on(0, "second start sample");
      pulse(4'h4);
      wait_on(1, "early restart idle");
      chk_rd("error flags", `STATUS_REG_ADDR, 32'h7, 32'h7);
      wr(`CONTROL_REG_ADDR, 32'h27);
      pulse(4'h4);
      wait_on(0, "trigger mode sample");
      chk_rd("restart and start clear", `FLOW_REG_ADDR, 32'h60, 32'h0);
      eol <= 1'b1;
      pulse(4'h4);
      wait_on(0, "restart at list end");
      chk_rd("no restart error", `STATUS_REG_ADDR, 32'h1, 32'h0);
      wr(`CONTROL_REG_ADDR, 32'h0);
      chk_rd("status after disable", `STATUS_REG_ADDR, 32'hf, 32'h0);
      chk_rd("flow after disable", `FLOW_REG_ADDR, 32'hff, 32'h0);
      results;
   end
endmodule // test_flow_ctl
